// File: rtl/wsi_wait_inserter.sv
// Overview of operation
// - One idle cycle between consecutive transfers on different chip selects.
// - During that idle cycle all byte, write, chip-select and read strobes are 1.
// - Early-read wait only for write then read on same chip select.
// - Early-read wait when write strobe has no hold and read has no setup.
// - Chip-select controlled write, no hold, no read chip-select setup: early-read wait.
// - Strobe controlled write, no hold, strobe still low: wait and hold bus.
// - After a mode write, one reload cycle loads the new parameter set.
// - Chip-select change absorbs the reload cycle; only the idle cycle is added.
// - Same chip select before and after a mode write: reload cycle always.
// - Mode register writes arm the reload; timing writes do not.
// - Entering or leaving slow-clock mode also arms the reload cycle.
// - Read followed by write always gets one read-to-write cycle.
// - Read-to-write cycle adds to idle and reload cycles.
// - Float wait after read: before read elsewhere, before any write.
// - Each chip select has its own float count from 0 to 15.
// - Internal accesses never wait on pending float cycles.
// - Strobe controlled read: float period starts at read strobe rise.
// - Chip-select controlled read: float period starts at chip-select rise.
// - Optimized float: next setup cycles count toward the float period.
// - Unoptimized float: period fully elapses before next access starts.
// - Read hold cycles overlapping the float period count toward it.
// - Write strobe hold is cycle length minus setup minus pulse.
// - All timings are held per chip select in whole clock cycles.
module wsi_wait_inserter
    import wsi_pkg::*;
#(
    parameter int N_CS = NUM_CS
) (
    // Clock, reset and clock enable.
    input  wire logic                  sys_clk,
    input  wire logic                  reset,
    input  wire logic                  clk_en,
    // Access requests from the internal bus.
    input  wire logic                  acc_valid,
    input  wire logic                  acc_write,
    input  wire logic                  acc_internal,
    input  wire logic [CS_W-1:0]       acc_cs,
    output logic                       acc_ready,
    // Start commands towards the strobe engine and internal memories.
    output logic                       ext_start,
    output logic                       ext_start_write,
    output logic [CS_W-1:0]            ext_start_cs,
    output logic                       int_start,
    // Status from the strobe engine.
    input  wire logic                  xfer_end,
    input  wire logic                  rd_strobe_rise,
    input  wire logic                  rd_cs_rise,
    input  wire logic                  write_strobe_fb_n,
    // Strobe levels from the strobe engine.
    input  wire logic [NBS_W-1:0]      eng_byte_select_n,
    input  wire logic [NWR_W-1:0]      eng_byte_write_n,
    input  wire logic [N_CS-1:0]       eng_chip_select_n,
    input  wire logic                  eng_read_strobe_n,
    // Strobes towards the pins.
    output logic [NBS_W-1:0]           byte_select_n,
    output logic [NWR_W-1:0]           byte_write_n,
    output logic [N_CS-1:0]            chip_select_n,
    output logic                       read_strobe_n,
    // Configuration events.
    input  wire logic                  mode_reg_write,
    input  wire logic                  slow_clock_mode,
    // Per chip select configuration, chip select 0 in the low bits.
    input  wire logic [N_CS-1:0]       cfg_write_mode,
    input  wire logic [N_CS-1:0]       cfg_read_mode,
    input  wire logic [N_CS-1:0]       cfg_tdf_mode,
    input  wire logic [N_CS*TDF_W-1:0] cfg_tdf_cycles,
    input  wire logic [N_CS*TW-1:0]    cfg_write_strobe_setup,
    input  wire logic [N_CS*TW-1:0]    cfg_write_strobe_pulse,
    input  wire logic [N_CS*TW-1:0]    cfg_write_cycle_length,
    input  wire logic [N_CS*TW-1:0]    cfg_cs_write_setup,
    input  wire logic [N_CS*TW-1:0]    cfg_cs_write_pulse,
    input  wire logic [N_CS*TW-1:0]    cfg_read_strobe_setup,
    input  wire logic [N_CS*TW-1:0]    cfg_cs_read_setup,
    // Status.
    output logic                       cfg_load,
    output logic                       addr_hold_ext,
    output logic                       cs_idle,
    output logic                       wait_active,
    output logic                       float_busy
);

    ////////////////////////////////////////////////////////////////////////////
    // Internal signals.
    wsi_state_e              state_r;
    wsi_state_e              state_nxt;
    logic [N_CS*CFG_W-1:0]   cfg_pack;
    logic [N_CS*CFG_W-1:0]   cfg_q;
    logic [CFG_W-1:0]        pcfg;
    logic [CFG_W-1:0]        ncfg;
    logic                    prev_valid_r;
    logic                    prev_write_r;
    logic [CS_W-1:0]         prev_cs_r;
    logic                    reload_pend_r;
    logic                    reload_pend_nxt;
    logic                    slow_q_r;
    logic [WCNT_W-1:0]       wait_cnt_r;
    logic                    flt_need_r;
    logic                    flt_opt_r;
    logic [TW-1:0]           flt_setup_r;
    logic                    pend_write_r;
    logic [CS_W-1:0]         pend_cs_r;
    logic [TDF_W-1:0]        float_rem;
    logic [TW-1:0]           float_rem_ext;
    logic                    float_start;
    logic                    take_int;
    logic                    take_ext;
    logic                    cs_chg;
    logic [TW-1:0]           p_we_hold;
    logic [TW-1:0]           p_cs_hold;
    logic [TW-1:0]           p_ctl_hold;
    logic [TW-1:0]           n_rd_setup;
    logic [TW-1:0]           n_setup;
    logic                    er_plain;
    logic                    er_cs;
    logic                    er_fb;
    logic                    early;
    logic                    reload_ins;
    logic                    rd2wr;
    logic                    flt_need;
    logic [WCNT_W-1:0]       fixed_cnt;
    logic                    flt_ok_now;
    logic                    flt_ok_wait;
    logic                    go_now;
    logic                    go_wait;

    ////////////////////////////////////////////////////////////////////////////
    // Pack the per chip select inputs into one word each.
    for (genvar i = 0; i < N_CS; i++) begin : g_pack
        assign cfg_pack[i*CFG_W +: CFG_W] = {cfg_cs_read_setup[i*TW +: TW],
                                             cfg_read_strobe_setup[i*TW +: TW],
                                             cfg_cs_write_pulse[i*TW +: TW],
                                             cfg_cs_write_setup[i*TW +: TW],
                                             cfg_write_cycle_length[i*TW +: TW],
                                             cfg_write_strobe_pulse[i*TW +: TW],
                                             cfg_write_strobe_setup[i*TW +: TW],
                                             cfg_tdf_cycles[i*TDF_W +: TDF_W],
                                             cfg_tdf_mode[i],
                                             cfg_read_mode[i],
                                             cfg_write_mode[i]};
    end

    // Active parameter sets, one per chip select.
    // Per chip-select timings.
    wsi_cfg_bank #(
        .N_CS    (N_CS)
    ) u_cfg_bank (
        .sys_clk (sys_clk),
        .reset   (reset),
        .clk_en  (clk_en),
        .load    (cfg_load),
        .cfg_in  (cfg_pack),
        .cfg_q   (cfg_q)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Float period timer, started at the rising edge of the read's controlling strobe.
    // Read strobe or chip-select rise start.
    assign float_start = !prev_write_r && prev_valid_r &&
                         (pcfg[F_RMODE] ? rd_strobe_rise : rd_cs_rise);

    wsi_float_timer u_float_timer (
        .sys_clk   (sys_clk),
        .reset     (reset),
        .clk_en    (clk_en),
        .start     (float_start),
        .start_val (pcfg[F_TDF +: TDF_W]),
        .remain    (float_rem)
    );

    assign float_rem_ext = {{(TW-TDF_W){1'b0}}, float_rem};

    ////////////////////////////////////////////////////////////////////////////
    // Boundary analysis between the previous external access and the offered one.
    always_comb begin
        pcfg       = cfg_q[prev_cs_r*CFG_W +: CFG_W];
        ncfg       = cfg_q[acc_cs*CFG_W +: CFG_W];
        cs_chg     = prev_valid_r && (acc_cs != prev_cs_r);
        p_we_hold  = pcfg[F_WR_CYCLE +: TW] - pcfg[F_WE_SETUP +: TW] - pcfg[F_WE_PULSE +: TW];
        p_cs_hold  = pcfg[F_WR_CYCLE +: TW] - pcfg[F_CS_WR_SETUP +: TW] - pcfg[F_CS_WR_PULSE +: TW];
        p_ctl_hold = pcfg[F_WMODE] ? p_we_hold : p_cs_hold;
        n_rd_setup = ncfg[F_RMODE] ? ncfg[F_RD_SETUP +: TW] : ncfg[F_CS_RD_SETUP +: TW];
        if (acc_write) begin
            n_setup = ncfg[F_WMODE] ? ncfg[F_WE_SETUP +: TW] : ncfg[F_CS_WR_SETUP +: TW];
        end else begin
            n_setup = n_rd_setup;
        end
        er_plain   = (p_ctl_hold == '0) && (n_rd_setup == '0);
        er_cs      = !pcfg[F_WMODE] && (p_cs_hold == '0) && (ncfg[F_CS_RD_SETUP +: TW] == '0);
        er_fb      = pcfg[F_WMODE] && (p_we_hold == '0) && !write_strobe_fb_n;
        early      = prev_valid_r && prev_write_r && !acc_write && !cs_chg &&
                     (er_plain || er_cs || er_fb);
        reload_ins = reload_pend_r && !cs_chg;
        rd2wr      = prev_valid_r && !prev_write_r && acc_write;
        fixed_cnt  = {2'b00, cs_chg} + {2'b00, early} + {2'b00, reload_ins} + {2'b00, rd2wr};
        flt_need   = prev_valid_r && !prev_write_r && (acc_write || cs_chg);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Float release test; the counter keeps running through every other wait cycle,
    // so idle, reload and read hold cycles all eat into the float period.
    // Setup overlaps float.
    assign flt_ok_now  = !flt_need ||
                         (pcfg[F_TMODE] ? (float_rem_ext <= n_setup) : (float_rem == '0));
    assign flt_ok_wait = !flt_need_r ||
                         (flt_opt_r ? (float_rem_ext <= flt_setup_r) : (float_rem == '0));

    // Request acceptance; internal requests bypass all external waits.
    // Internal never stalls.
    assign take_int = acc_valid && acc_ready && acc_internal;
    assign take_ext = acc_valid && acc_ready && !acc_internal;
    assign go_now   = take_ext && (fixed_cnt == '0) && flt_ok_now;
    assign go_wait  = (state_r == ST_WAIT) && (wait_cnt_r <= 3'h1) && flt_ok_wait;

    ////////////////////////////////////////////////////////////////////////////
    // Next state of the sequencer.
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (go_now) begin
                    state_nxt = ST_BUSY;
                end else if (take_ext) begin
                    state_nxt = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (go_wait) begin
                    state_nxt = ST_BUSY;
                end
            end
            ST_BUSY: begin
                if (xfer_end) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // State register.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state_r <= ST_IDLE;
        end else if (clk_en) begin
            state_r <= state_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Fixed wait counter and the float terms of the pending access.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            wait_cnt_r  <= '0;
            flt_need_r  <= 1'b0;
            flt_opt_r   <= 1'b0;
            flt_setup_r <= '0;
        end else if (clk_en) begin
            if (take_ext) begin
                wait_cnt_r  <= fixed_cnt;
                flt_need_r  <= flt_need;
                flt_opt_r   <= pcfg[F_TMODE];
                flt_setup_r <= n_setup;
            end else if ((state_r == ST_WAIT) && (wait_cnt_r != '0)) begin
                wait_cnt_r  <= wait_cnt_r - 3'h1;
            end
        end
    end

    // Last accepted external access and the pending start target.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            prev_valid_r <= 1'b0;
            prev_write_r <= 1'b0;
            prev_cs_r    <= '0;
            pend_write_r <= 1'b0;
            pend_cs_r    <= '0;
        end else if (clk_en && take_ext) begin
            prev_valid_r <= 1'b1;
            prev_write_r <= acc_write;
            prev_cs_r    <= acc_cs;
            pend_write_r <= acc_write;
            pend_cs_r    <= acc_cs;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reload request, armed by mode writes and slow-clock changes; an arming event
    // in the cycle that consumes the request keeps it pending.
    // Mode writes and slow-clock changes.
    assign reload_pend_nxt = mode_reg_write || (slow_clock_mode != slow_q_r) ||
                             (reload_pend_r && !take_ext);

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            reload_pend_r <= 1'b1;
            slow_q_r      <= 1'b0;
        end else if (clk_en) begin
            reload_pend_r <= reload_pend_nxt;
            slow_q_r      <= slow_clock_mode;
        end
    end

    // Parameter load in the first wait cycle, reload cycle or absorbing idle cycle.
    // Idle absorbs reload.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            cfg_load <= 1'b0;
        end else if (clk_en) begin
            cfg_load <= take_ext && reload_pend_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Handshake and start pulses.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            acc_ready       <= 1'b0;
            ext_start       <= 1'b0;
            ext_start_write <= 1'b0;
            ext_start_cs    <= '0;
            int_start       <= 1'b0;
            wait_active     <= 1'b0;
            float_busy      <= 1'b0;
        end else if (clk_en) begin
            acc_ready       <= (state_nxt == ST_IDLE);
            ext_start       <= go_now || go_wait;
            ext_start_write <= go_now ? acc_write : pend_write_r;
            ext_start_cs    <= go_now ? acc_cs : pend_cs_r;
            int_start       <= take_int;
            wait_active     <= (state_nxt == ST_WAIT);
            float_busy      <= (float_rem != '0);
        end
    end

    // Bus hold extension while the write strobe feedback is late.
    // Extra hold cycle.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            addr_hold_ext <= 1'b0;
        end else if (clk_en) begin
            addr_hold_ext <= take_ext && early && er_fb;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin strobes, forced inactive during the chip-select idle cycle.
    // Idle forces ones.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            cs_idle       <= 1'b0;
            byte_select_n <= '1;
            byte_write_n  <= '1;
            chip_select_n <= '1;
            read_strobe_n <= 1'b1;
        end else if (clk_en) begin
            cs_idle       <= take_ext && cs_chg;
            byte_select_n <= (take_ext && cs_chg) ? '1 : eng_byte_select_n;
            byte_write_n  <= (take_ext && cs_chg) ? '1 : eng_byte_write_n;
            chip_select_n <= (take_ext && cs_chg) ? '1 : eng_chip_select_n;
            read_strobe_n <= (take_ext && cs_chg) ? 1'b1 : eng_read_strobe_n;
        end
    end

endmodule : wsi_wait_inserter

// File: rtl/wsi_pkg.sv
package wsi_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Sizes of the external interface.
    localparam int NUM_CS = 8;                // Number of chip selects.
    localparam int CS_W   = 3;                // Width of a chip-select index.
    localparam int NBS_W  = 4;                // Byte-select lines.
    localparam int NWR_W  = 4;                // Byte-write lines.
    localparam int TW     = 10;               // Width of an effective timing count.
    localparam int TDF_W  = 4;                // Width of the float cycle count.
    localparam int WCNT_W = 3;                // Width of the fixed wait counter.

    ////////////////////////////////////////////////////////////////////////////
    // Field positions inside one chip select's packed configuration word.
    localparam int F_WMODE       = 0;         // Write controlled by write strobe when 1.
    localparam int F_RMODE       = 1;         // Read controlled by read strobe when 1.
    localparam int F_TMODE       = 2;         // Float optimization enabled when 1.
    localparam int F_TDF         = 3;         // Float cycle count, TDF_W bits.
    localparam int F_WE_SETUP    = F_TDF + TDF_W;
    localparam int F_WE_PULSE    = F_WE_SETUP + TW;
    localparam int F_WR_CYCLE    = F_WE_PULSE + TW;
    localparam int F_CS_WR_SETUP = F_WR_CYCLE + TW;
    localparam int F_CS_WR_PULSE = F_CS_WR_SETUP + TW;
    localparam int F_RD_SETUP    = F_CS_WR_PULSE + TW;
    localparam int F_CS_RD_SETUP = F_RD_SETUP + TW;
    localparam int CFG_W         = F_CS_RD_SETUP + TW;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values of the active parameter set.
    localparam logic [TW-1:0]    RST_SETUP = 10'h001;
    localparam logic [TW-1:0]    RST_PULSE = 10'h001;
    localparam logic [TW-1:0]    RST_CYCLE = 10'h003;
    localparam logic [TDF_W-1:0] RST_TDF   = 4'h0;
    localparam logic [CFG_W-1:0] CFG_RST   = {RST_SETUP, RST_SETUP, RST_PULSE, RST_SETUP,
                                              RST_CYCLE, RST_PULSE, RST_SETUP, RST_TDF,
                                              1'b0, 1'b1, 1'b1};

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer states.
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_BUSY = 2'b10
    } wsi_state_e;

endpackage : wsi_pkg

// File: rtl/wsi_cfg_bank.sv
module wsi_cfg_bank
    import wsi_pkg::*;
#(
    parameter int N_CS = NUM_CS
) (
    // Clock and reset.
    input  wire logic                  sys_clk,
    input  wire logic                  reset,
    input  wire logic                  clk_en,
    // Load strobe and parameter sets.
    input  wire logic                  load,
    input  wire logic [N_CS*CFG_W-1:0] cfg_in,
    output logic      [N_CS*CFG_W-1:0] cfg_q
);

    ////////////////////////////////////////////////////////////////////////////
    // One active parameter word per chip select, replaced only on a load.
    for (genvar i = 0; i < N_CS; i++) begin : g_cs
        always_ff @(posedge sys_clk or posedge reset) begin
            if (reset) begin
                cfg_q[i*CFG_W +: CFG_W] <= CFG_RST;
            end else if (clk_en && load) begin
                cfg_q[i*CFG_W +: CFG_W] <= cfg_in[i*CFG_W +: CFG_W];
            end
        end
    end

endmodule : wsi_cfg_bank

// File: rtl/wsi_float_timer.sv
module wsi_float_timer
    import wsi_pkg::*;
(
    // Clock and reset.
    input  wire logic             sys_clk,
    input  wire logic             reset,
    input  wire logic             clk_en,
    // Start of a float period and its length.
    input  wire logic             start,
    input  wire logic [TDF_W-1:0] start_val,
    // Float cycles still to run.
    output logic      [TDF_W-1:0] remain
);

    ////////////////////////////////////////////////////////////////////////////
    // Down counter that stops at zero; a new start overrides the count.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            remain <= '0;
        end else if (clk_en) begin
            if (start) begin
                remain <= start_val;
            end else if (remain != '0) begin
                remain <= remain - 4'h1;
            end
        end
    end

endmodule : wsi_float_timer

// File: bench/wsi_wait_inserter_monitor.sv
module wsi_wait_inserter_monitor
    import wsi_pkg::*;
(
    // Clock, reset and requests.
    input wire logic              sys_clk, reset, clk_en, acc_valid, acc_write, acc_internal, acc_ready,
    input wire logic [CS_W-1:0]   acc_cs,
    input wire logic              slow_clock_mode,
    // Outputs under watch.
    input wire logic              ext_start, int_start, cs_idle, cfg_load, mode_reg_write, read_strobe_n,
    input wire logic [NBS_W-1:0]  byte_select_n,
    input wire logic [NWR_W-1:0]  byte_write_n,
    input wire logic [NUM_CS-1:0] chip_select_n
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    logic            take, same, seen_r, last_rd_r, pend_r, slow_q_r;
    logic [CS_W-1:0] last_cs_r;
    assign take = clk_en && acc_valid && acc_ready && !acc_internal;
    assign same = take && seen_r && acc_cs == last_cs_r;
    // Remembers the previous external access and a pending reload.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            {seen_r, last_rd_r, pend_r, slow_q_r, last_cs_r} <= {4'h2, 3'h0};
        end else if (clk_en) begin
            pend_r   <= mode_reg_write || slow_clock_mode != slow_q_r || (pend_r && !take);
            slow_q_r <= slow_clock_mode;
            if (take) {seen_r, last_rd_r, last_cs_r} <= {1'b1, !acc_write, acc_cs};
        end
    end
    a_idle_strobes_high: assert property (cs_idle |-> &{byte_select_n, byte_write_n, chip_select_n, read_strobe_n})
        else $error("strobe active in idle cycle");
    a_idle_one_cycle: assert property (cs_idle |=> !cs_idle)
        else $error("idle cycle too long");
    a_cs_change_idle: assert property (take && seen_r && acc_cs != last_cs_r |=> cs_idle)
        else $error("no idle cycle on chip select change");
    a_read_to_write: assert property (take && seen_r && last_rd_r && acc_write |=> !ext_start)
        else $error("write started without wait after read");
    a_reload_same_cs: assert property (same && pend_r |=> cfg_load)
        else $error("no reload cycle");
    a_read_no_wait: assert property (same && last_rd_r && !acc_write && !pend_r && !mode_reg_write |=> ext_start)
        else $error("needless wait between reads");
    a_internal_free: assert property (clk_en && acc_valid && acc_ready && acc_internal |=> int_start)
        else $error("internal access delayed");
    a_ready_drops: assert property (take |=> !acc_ready && !int_start)
        else $error("ready stayed high after take");
endmodule : wsi_wait_inserter_monitor

bind wsi_wait_inserter wsi_wait_inserter_monitor i_monitor (.*);

// File: bench/wsi_engine_model.sv
module wsi_engine_model
    import wsi_pkg::*;
(
    // Start command from the block.
    input wire logic              sys_clk, reset, ext_start, ext_start_write,
    input wire logic [CS_W-1:0]   ext_start_cs,
    // Status and strobe levels back to the block.
    output logic                  xfer_end, rd_strobe_rise, rd_cs_rise, write_strobe_fb_n, eng_read_strobe_n,
    output logic [NBS_W-1:0]      eng_byte_select_n, eng_byte_write_n,
    output logic [NUM_CS-1:0]     eng_chip_select_n
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0]      cnt_r;
    logic            wr_r, act, wr;
    logic [CS_W-1:0] cs_r, cs;
    assign act = ext_start || cnt_r > 2'h1;
    assign wr = ext_start ? ext_start_write : wr_r;
    assign cs = ext_start ? ext_start_cs : cs_r;
    // Each access lasts three cycles; strobes go inactive with the end pulse.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            {cnt_r, wr_r, cs_r, xfer_end, rd_strobe_rise, rd_cs_rise} <= '0;
            {write_strobe_fb_n, eng_read_strobe_n, eng_byte_select_n, eng_byte_write_n, eng_chip_select_n} <= '1;
        end else begin
            {xfer_end, rd_strobe_rise, rd_cs_rise} <= {cnt_r == 2'h1, {2{cnt_r == 2'h1 && !wr_r}}};
            cnt_r <= ext_start ? 2'h3 : cnt_r - 2'(cnt_r != 2'h0);
            {wr_r, cs_r} <= {wr, cs};
            {eng_read_strobe_n, write_strobe_fb_n} <= {!(act && !wr), !(act && wr)};
            {eng_byte_select_n, eng_byte_write_n} <= {{4{!act}}, {4{!(act && wr)}}};
            eng_chip_select_n <= act ? ~(8'h01 << cs) : '1;
        end
    end
endmodule : wsi_engine_model

// File: bench/wsi_wait_inserter_tb_top.sv
module wsi_wait_inserter_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import wsi_pkg::*;
    localparam logic [79:0] ONE = {8{10'h001}};
    logic sys_clk = 0, reset = 1, clk_en = 1, acc_valid = 0, acc_write = 0, acc_internal = 0;
    logic mode_reg_write = 0, slow_clock_mode = 0, acc_ready, ext_start, ext_start_write, int_start, xfer_end;
    logic rd_strobe_rise, rd_cs_rise, write_strobe_fb_n, eng_read_strobe_n, read_strobe_n, cfg_load;
    logic addr_hold_ext, cs_idle, wait_active, float_busy;
    logic [2:0]  acc_cs = 0, ext_start_cs;
    logic [3:0]  eng_byte_select_n, eng_byte_write_n, byte_select_n, byte_write_n;
    logic [7:0]  eng_chip_select_n, chip_select_n, cfg_write_mode = 8'hFF, cfg_read_mode = 8'hFF, cfg_tdf_mode = 0, n;
    logic [31:0] cfg_tdf_cycles = 0;
    logic [79:0] cfg_write_strobe_setup = ONE, cfg_write_strobe_pulse = ONE, cfg_write_cycle_length = {8{10'h003}};
    logic [79:0] cfg_cs_write_setup = ONE, cfg_cs_write_pulse = ONE, cfg_read_strobe_setup = ONE, cfg_cs_read_setup = ONE;
    int num_errors = 0, n_checks = 0;
    wsi_wait_inserter i_wsi_wait_inserter (.*);
    wsi_engine_model i_wsi_engine_model (.*);
    always #25 sys_clk = ~sys_clk;
    // Compares one value and reports a mismatch.
    task automatic chk(input logic [7:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Issues one access and counts cycles from take to start; exp 0 skips the count check.
    task automatic t(input logic w, i, input logic [2:0] cs, input logic [7:0] exp);
        n = 8'h00;
        @(posedge sys_clk);
        {acc_valid, acc_write, acc_internal, acc_cs} <= {1'b1, w, i, cs};
        do @(negedge sys_clk); while (!acc_ready);
        @(posedge sys_clk) acc_valid <= 1'b0;
        do begin @(negedge sys_clk); n++; end while (!(ext_start || int_start) && n < 8'h40);
        if (!i) chk(8'({ext_start_write, ext_start_cs}), 8'({w, cs}));
        while (!acc_ready) @(negedge sys_clk);
        if (exp != 8'h00) chk(n, exp);
        $display("test ended after %0d cycles", n);
    endtask : t
    // Pulses the mode register write strobe.
    task automatic mw;
        @(posedge sys_clk) mode_reg_write <= 1'b1;
        @(posedge sys_clk) mode_reg_write <= 1'b0;
    endtask : mw
    task automatic conclude;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : conclude
    // Watchdog against a hang.
    initial begin
        #200000;
        num_errors++;
        conclude;
    end
    // Main sequence.
    initial begin
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        t(0, 0, 3'h0, 0);
        t(0, 0, 3'h0, 1);
        t(0, 1, 3'h0, 1);
        @(posedge sys_clk) slow_clock_mode <= 1'b1;
        t(0, 0, 3'h0, 2);
        t(1, 0, 3'h2, 3);
        t(1, 0, 3'h2, 1);
        mw; t(1, 0, 3'h2, 2);
        mw; t(0, 0, 3'h5, 2);
        @(posedge sys_clk);
        {cfg_write_mode[5], cfg_write_cycle_length[59:50], cfg_cs_read_setup[59:50]} <= {1'b0, 10'h002, 10'h000};
        mw; t(1, 0, 3'h5, 3);
        t(0, 0, 3'h5, 2);
        @(posedge sys_clk);
        {cfg_tdf_cycles[23:20], cfg_tdf_mode[5], cfg_read_mode[5], cfg_read_strobe_setup[59:50]} <= {4'hF, 2'h0, 10'h2};
        mw; t(0, 0, 3'h5, 2);
        t(1, 0, 3'h5, 8'h0F);
        @(posedge sys_clk) {cfg_tdf_mode[5], cfg_read_mode[5]} <= 2'h3;
        mw; t(0, 0, 3'h5, 3);
        t(1, 0, 3'h5, 8'h0E);
        conclude;
    end
endmodule : wsi_wait_inserter_tb_top
